// ### test/host_model.sv
// host control unit model: sends framed commands and collects responses with random stalls
`timescale 1ns/10ps
module host_model (
	input  wire logic       core_clk,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            rx_last,
	output logic            rx_parity_err,
	output logic            rx_framing_err,
	output logic            rx_overrun_err,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last
);
	logic [7:0]  cur_q[$];
	logic [7:0]  rsp_q[$];
	int          n_rsp   = 0;
	logic [31:0] stall_q = 32'h969a;

	// quiet link at time zero
	initial begin
		{rx_valid, rx_last, rx_parity_err, rx_framing_err, rx_overrun_err} = 5'h00;
		rx_data  = 8'h00;
	end

	// take response characters; stalls let the fifo fill up behind us
	always @(posedge core_clk) begin
		if (tx_valid && tx_ready) begin
			cur_q.push_back(tx_data);
			if (tx_last) begin
				rsp_q = cur_q;
				cur_q = {};
				n_rsp++;
			end
		end
		stall_q  <= {stall_q[30:0], stall_q[31] ^ stall_q[21] ^ stall_q[1] ^ stall_q[0]};
		tx_ready <= stall_q[3] | stall_q[7];
	end

	// one frame, back to back characters, check byte appended; err goes on character at
	task send_frame(input logic [7:0] b[$], input int at, input logic [2:0] err, input logic bad);
		logic [7:0] bcc;
		bcc = 8'h00;
		foreach (b[i]) bcc ^= b[i];
		b.push_back(bad ? ~bcc : bcc);
		foreach (b[i]) begin
			rx_valid <= 1'b1;
			rx_data  <= b[i];
			rx_last  <= (i == b.size() - 1);
			{rx_parity_err, rx_framing_err, rx_overrun_err} <= (i == at) ? err : 3'h0;
			@(posedge core_clk);
		end
		{rx_valid, rx_last, rx_parity_err, rx_framing_err, rx_overrun_err} <= 5'h00;
		rx_data <= ~rx_data; // released line must not keep the last value
	endtask : send_frame
endmodule : host_model

// ### test/testbench.sv
// self-checking bench for the tag reader command handler
`timescale 1ns/10ps
module testbench
	import tag_cmd_pkg::*;
;
	logic        core_clk, sys_rst, rx_valid, rx_last, rx_parity_err, rx_framing_err, rx_overrun_err;
	logic        tx_valid, tx_ready, tx_last, tag_req, tag_abort, tag_first_gen, tag_rd_valid, tag_done;
	logic        antenna_on, gen1;
	logic [7:0]  rx_data, tx_data, tag_rd_data, tag_iso_code;
	logic [3:0]  tag_page;
	logic [2:0]  tag_status;
	logic [15:0] map;
	logic [31:0] seed = 32'h969a;
	logic [7:0]  q[$], e[$];
	logic        saw_abort = 1'b0;
	int          n_mismatch = 0, n_checks = 0, rsp_seen = 0, tag_wait = 0;
	logic [2:0]  err_tab[6] = '{3'h4, 3'h2, 3'h1, 3'h5, 3'h3, 3'h0};
	logic [7:0]  err_ec[6]  = '{EC_PARITY, EC_FRAMING, EC_OVERRUN, EC_PARITY, EC_FRAMING, EC_BCC};
	logic [2:0]  st_tab[13] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4};
	logic [7:0]  iso_tab[13] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h0f, ISO_ABSENT, ISO_LOCKED,
		ISO_WPROT, ISO_WFAIL, ISO_LFAIL, 8'h55};
	logic [7:0]  ec_tab[13] = '{EC_COMM, EC_NOTAG, EC_WRITE, EC_CMD, EC_CMD, EC_CMD, EC_CMD, EC_ADDR, EC_NORMAL,
		EC_WRITE, EC_WRITE, EC_WRITE, EC_CMD};

	tag_cmd_handler tag_cmd_handler_inst (.core_clk(core_clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_last(rx_last), .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
		.rx_overrun_err(rx_overrun_err), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_last(tx_last), .tag_req(tag_req), .tag_page(tag_page), .tag_abort(tag_abort),
		.tag_first_gen(tag_first_gen), .tag_rd_valid(tag_rd_valid), .tag_rd_data(tag_rd_data),
		.tag_done(tag_done), .tag_status(tag_status), .tag_iso_code(tag_iso_code), .antenna_on(antenna_on));
	host_model host_model_inst (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err), .rx_overrun_err(rx_overrun_err),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

	// ************************************************************
	// clock, helpers, tag engine model
	// ************************************************************
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	function logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd

	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task end_of_test();
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// gap first: frames landing while a response drains would be dropped
	task send(input logic [2:0] err, input int at, input logic bad);
		repeat (3) @(posedge core_clk);
		host_model_inst.send_frame(q, at, err, bad);
	endtask : send

	task read_frame(input logic [7:0] mode, input logic [15:0] m);
		q = {CMD_READ, mode, 8'h00, m[15:8], m[7:0]};
		send(3'h0, 0, 1'b0);
	endtask : read_frame

	// expected read: end code, then eight characters per selected page in visit order
	task exp_read(input logic [15:0] m, input logic g1);
		logic [3:0] p;
		e = {EC_NORMAL};
		for (int k = 0; k < 16; k++) begin
			p = (g1 ? FIRST_PAGE_GEN1 : 4'h0) + 4'(k);
			if (m[p]) for (int i = 0; i < 8; i++) e.push_back({p, 4'(i)});
		end
	endtask : exp_read

	task expect_rsp();
		int k;
		k = 0;
		while (host_model_inst.n_rsp == rsp_seen && k < 4000) begin
			@(posedge core_clk);
			k++;
		end
		rsp_seen = host_model_inst.n_rsp;
		check("rsp_arrived", 8'(k < 4000), 8'h01);
		check("rsp_len", 8'(host_model_inst.rsp_q.size()), 8'(e.size()));
		foreach (e[i]) check("rsp_byte", host_model_inst.rsp_q[i], e[i]);
	endtask : expect_rsp

	// abort flag is cleared by each new request so a stale stop cannot satisfy a later check
	always @(posedge core_clk) begin
		if (tag_abort === 1'b1) saw_abort <= 1'b1;
		else if (tag_req === 1'b1) saw_abort <= 1'b0;
	end
	// tag engine: page data is page number and index; stops waiting on abort
	initial begin
		logic aborted;
		{tag_rd_valid, tag_done} = 2'h0;
		tag_rd_data = 8'h00;
		forever begin
			@(posedge core_clk);
			if (tag_req === 1'b1) begin
				aborted = 1'b0;
				for (int k = 0; k < tag_wait + 2 && !aborted; k++) begin
					@(posedge core_clk);
					aborted = (tag_abort === 1'b1);
				end
				if (!aborted) begin
					for (int i = 0; i < 8; i++) begin
						tag_rd_valid <= 1'b1;
						tag_rd_data  <= {tag_page, 4'(i)};
						@(posedge core_clk);
					end
					tag_rd_valid <= 1'b0;
					tag_done     <= 1'b1;
					@(posedge core_clk);
					tag_done    <= 1'b0;
					tag_rd_data <= ~tag_rd_data;
				end
			end
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		sys_rst = 1'b1;
		{tag_first_gen, tag_iso_code, tag_status} = 12'h000;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		// echo: 73-byte frame is the longest legal one, 74 is refused
		for (int t = 0; t < 6; t++) begin
			q = {CMD_ECHO};
			repeat (t == 0 ? 71 : t == 1 ? 72 : 1 + rnd() % 8) q.push_back(rnd());
			e = q;
			e[0] = EC_NORMAL;
			if (t == 1) e = {EC_FRAME};
			send(3'h0, 0, 1'b0);
			expect_rsp();
		end
		// link errors, combined with a bad check byte to exercise the priority
		for (int t = 0; t < 6; t++) begin
			q = {CMD_ECHO, rnd(), rnd()};
			e = {err_ec[t]};
			send(err_tab[t], rnd() % 4, 1'b1);
			expect_rsp();
		end
		q = {CMD_NACK};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		q = {CMD_ACK};
		send(3'h0, 0, 1'b0);
		repeat (40) @(posedge core_clk);
		check("ack_silent", 8'(host_model_inst.n_rsp - rsp_seen), 8'h00);
		// undefined code, empty page map, short read frame
		e = {EC_FORMAT};
		q = {8'h20};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		read_frame(8'h00, 16'h0000);
		expect_rsp();
		q = {CMD_READ, 8'h00, 8'h00, 8'h01};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		// one-shot reads, random maps, both tag generations, full map last
		for (int t = 0; t < 5; t++) begin
			map  = (t == 4) ? 16'hffff : {rnd(), rnd()} | 16'h0001;
			gen1 = (t == 4) | seed[9];
			tag_first_gen <= gen1;
			read_frame(8'h00, map);
			exp_read(map, gen1);
			expect_rsp();
			check("antenna_off", 8'(antenna_on), 8'h00);
		end
		tag_first_gen <= 1'b0;
		// tag status and tag error code translation
		for (int t = 0; t < 13; t++) begin
			tag_status   <= st_tab[t];
			tag_iso_code <= iso_tab[t];
			map = 16'h0001 << (rnd() & 8'h0f);
			read_frame(8'h00, map);
			if (ec_tab[t] == EC_NORMAL) exp_read(map, 1'b0);
			else e = {ec_tab[t]};
			expect_rsp();
		end
		tag_status <= TST_OK;
		// continuous mode: acknowledge rereads, resend repeats, stop sleeps
		read_frame(MODE_CONT, 16'h8001);
		exp_read(16'h8001, 1'b0);
		expect_rsp();
		check("antenna_on", 8'(antenna_on), 8'h01);
		q = {CMD_ACK};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		q = {CMD_NACK};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		q = {CMD_STOP};
		e = {EC_NORMAL};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		check("antenna_sleep", 8'(antenna_on), 8'h00);
		// stop while the tag is still busy
		tag_wait = 300;
		read_frame(8'h00, 16'h0010);
		repeat (20) @(posedge core_clk);
		q = {CMD_STOP};
		send(3'h0, 0, 1'b0);
		expect_rsp();
		check("abort_seen", 8'(saw_abort), 8'h01);
		check("antenna_stop", 8'(antenna_on), 8'h00);
		end_of_test();
	end

	// watchdog: whole run is far shorter than this
	initial begin
		repeat (60000) @(posedge core_clk);
		n_mismatch++;
		end_of_test();
	end
endmodule : testbench

// ### verilog/rsp_fifo.sv
// first-in first-out buffer for response characters on their way to the host link
`timescale 1ns/10ps
module rsp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// honest flags straight from the fill count
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_q[rd_q];

	// storage has no reset; only the pointers and the fill count carry control state
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : rsp_fifo

// ### verilog/tag_cmd_handler.sv
// command handler between the host serial link and the contactless tag engine
// Functional notes
// - parity error in command answers 10
// - framing error in command answers 11
// - overrun error in command answers 12
// - bad check byte answers 13
// - unknown code or bad pages answer 14
// - frame over 73 bytes answers 18
// - disturbed tag exchange reports 70
// - write refused or worn out reports 71
// - no tag present reports 72
// - tag codes 01,02,03,0F,reserved give 79
// - tag code 10 gives 7A
// - tag code 11 gives normal 00
// - tag codes 12,13,14 give 71
// - echo command returns 00 plus same bytes
// - acknowledge command gets no response, except while awaiting acknowledge in continuous mode
// - resend request repeats last response exactly
// - stop aborts, antenna off, sleep, end code
// - read answers 00 then 8 characters/page
// - first-generation tags read from page B wrapping
// - continuous mode rereads after acknowledge
`timescale 1ns/10ps
module tag_cmd_handler
	import tag_cmd_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_last,
	input  wire logic       rx_parity_err,
	input  wire logic       rx_framing_err,
	input  wire logic       rx_overrun_err,
	output logic            tx_valid,
	input  wire logic       tx_ready,
	output logic      [7:0] tx_data,
	output logic            tx_last,
	output logic            tag_req,
	output logic      [3:0] tag_page,
	output logic            tag_abort,
	input  wire logic       tag_first_gen,
	input  wire logic       tag_rd_valid,
	input  wire logic [7:0] tag_rd_data,
	input  wire logic       tag_done,
	input  wire logic [2:0] tag_status,
	input  wire logic [7:0] tag_iso_code,
	output logic            antenna_on
);

	// ************************************************************
	// declarations
	// ************************************************************
	typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_TAG, ST_SEND, ST_ACK_WAIT} state_e;

	state_e      state_q;
	logic [7:0]  rx_cnt_q;
	logic [7:0]  bcc_q;
	logic        perr_q, ferr_q, oerr_q;
	logic [7:0]  code_q, opt_q, map_hi_q;
	logic [15:0] map_q;
	logic        frame_done_q;
	logic [7:0]  fr_err_q;
	logic [7:0]  fr_len_q;
	logic [7:0]  rsp_mem [RSP_DEPTH];
	logic [7:0]  rsp_len_q;
	logic [7:0]  idx_q;
	logic [7:0]  wr_idx_q;
	logic [3:0]  page_q;
	logic [4:0]  steps_q;
	logic        cont_q;
	logic        tag_req_q, tag_abort_q, antenna_q;
	logic        f_in_ready, f_out_valid;
	logic [8:0]  f_out_data;
	logic        push;
	logic        cmd_ok, is_stop, is_ack, is_nack;

	// ************************************************************
	// helper functions
	// ************************************************************
	// one host-link code per frame, tested in a fixed order
	function automatic logic [7:0] host_err(input logic p, input logic f, input logic o,
	                                        input logic bad_bcc, input logic too_long);
		if (p)             return EC_PARITY;
		else if (f)        return EC_FRAMING;
		else if (o)        return EC_OVERRUN;
		else if (bad_bcc)  return EC_BCC;
		else if (too_long) return EC_FRAME;
		else               return EC_NORMAL;
	endfunction : host_err

	// maps a tag engine result onto a module end code
	function automatic logic [7:0] tag_xlate(input logic [2:0] st, input logic [7:0] iso);
		case (st)
			TST_OK:    return EC_NORMAL;
			TST_COMM:  return EC_COMM;
			TST_NOTAG: return EC_NOTAG;
			TST_WRITE: return EC_WRITE;
			default: begin
				case (iso)
					ISO_ABSENT: return EC_ADDR;
					ISO_LOCKED: return EC_NORMAL;
					ISO_WPROT, ISO_WFAIL, ISO_LFAIL: return EC_WRITE;
					default:    return EC_CMD;
				endcase
			end
		endcase
	endfunction : tag_xlate

	// ************************************************************
	// frame reception
	// ************************************************************
	// check byte is the exclusive-or of every byte before it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rx_cnt_q     <= '0;
			bcc_q        <= '0;
			perr_q       <= 1'b0;
			ferr_q       <= 1'b0;
			oerr_q       <= 1'b0;
			code_q       <= '0;
			opt_q        <= '0;
			map_hi_q     <= '0;
			map_q        <= '0;
			frame_done_q <= 1'b0;
			fr_err_q     <= '0;
			fr_len_q     <= '0;
		end else begin
			frame_done_q <= 1'b0;
			if (rx_valid && rx_last) begin
				frame_done_q <= 1'b1;
				fr_len_q     <= rx_cnt_q;
				fr_err_q     <= host_err(perr_q | rx_parity_err, ferr_q | rx_framing_err,
				                         oerr_q | rx_overrun_err, rx_data != bcc_q,
				                         rx_cnt_q >= 8'(MAX_FRAME));
				rx_cnt_q     <= '0;
				bcc_q        <= '0;
				perr_q       <= 1'b0;
				ferr_q       <= 1'b0;
				oerr_q       <= 1'b0;
			end else if (rx_valid) begin
				rx_cnt_q <= (rx_cnt_q == 8'hff) ? rx_cnt_q : rx_cnt_q + 8'h01;
				bcc_q    <= bcc_q ^ rx_data;
				perr_q   <= perr_q | rx_parity_err;
				ferr_q   <= ferr_q | rx_framing_err;
				oerr_q   <= oerr_q | rx_overrun_err;
				case (rx_cnt_q)
					8'h00:   code_q   <= rx_data;
					8'h01:   opt_q    <= rx_data;
					8'h03:   map_hi_q <= rx_data;
					8'h04:   map_q    <= {map_hi_q, rx_data};
					default: ;
				endcase
			end
		end
	end

	assign cmd_ok  = frame_done_q && (fr_err_q == EC_NORMAL);
	assign is_stop = cmd_ok && (code_q == CMD_STOP);
	assign is_ack  = cmd_ok && (code_q == CMD_ACK);
	assign is_nack = cmd_ok && (code_q == CMD_NACK);

	// ************************************************************
	// response store
	// ************************************************************
	// echo bytes land in place while received; the old response is only lost when a new one replaces it
	always_ff @(posedge core_clk) begin
		if (state_q == ST_IDLE && frame_done_q) begin
			if (fr_err_q != EC_NORMAL) begin
				rsp_mem[0] <= fr_err_q;
			end else if (code_q == CMD_ECHO || code_q == CMD_STOP) begin
				rsp_mem[0] <= EC_NORMAL;
			end else if (code_q != CMD_ACK && code_q != CMD_NACK &&
			             (code_q != CMD_READ || fr_len_q != 8'(READ_LEN) || map_q == '0)) begin
				rsp_mem[0] <= EC_FORMAT;
			end
		end else if (state_q == ST_IDLE && rx_valid && !rx_last && code_q == CMD_ECHO &&
		             rx_cnt_q != 8'h00 && rx_cnt_q < 8'(RSP_DEPTH)) begin
			rsp_mem[rx_cnt_q] <= rx_data;
		end else if ((state_q == ST_SCAN || state_q == ST_TAG || state_q == ST_ACK_WAIT) && is_stop) begin
			rsp_mem[0] <= EC_NORMAL;
		end else if (state_q == ST_TAG && tag_rd_valid && wr_idx_q < 8'(RSP_DEPTH)) begin
			rsp_mem[wr_idx_q] <= tag_rd_data;
		end else if (state_q == ST_TAG && tag_done) begin
			rsp_mem[0] <= tag_xlate(tag_status, tag_iso_code);
		end else if (state_q == ST_SCAN && steps_q == 5'(NUM_PAGES)) begin
			rsp_mem[0] <= EC_NORMAL;
		end
	end

	// ************************************************************
	// command sequencing
	// ************************************************************
	// a page visit takes one scan step whether selected or not, so the order is fixed by the scan
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q   <= ST_IDLE;
			rsp_len_q <= 8'h01;
			idx_q     <= '0;
			wr_idx_q  <= 8'h01;
			page_q    <= '0;
			steps_q   <= '0;
			cont_q    <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (frame_done_q) begin
						idx_q <= '0;
						if (fr_err_q != EC_NORMAL) begin
							rsp_len_q <= 8'h01;
							state_q   <= ST_SEND;
						end else if (code_q == CMD_ECHO) begin
							rsp_len_q <= fr_len_q;
							state_q   <= ST_SEND;
						end else if (code_q == CMD_NACK) begin
							state_q <= ST_SEND;
						end else if (code_q == CMD_READ && fr_len_q == 8'(READ_LEN) && map_q != '0) begin
							cont_q   <= (opt_q == MODE_CONT);
							page_q   <= tag_first_gen ? FIRST_PAGE_GEN1 : 4'h0;
							steps_q  <= '0;
							wr_idx_q <= 8'h01;
							state_q  <= ST_SCAN;
						end else if (code_q != CMD_ACK) begin
							rsp_len_q <= 8'h01;
							state_q   <= ST_SEND;
						end
					end
				end
				ST_SCAN: begin
					if (is_stop) begin
						rsp_len_q <= 8'h01;
						cont_q    <= 1'b0;
						idx_q     <= '0;
						state_q   <= ST_SEND;
					end else if (steps_q == 5'(NUM_PAGES)) begin
						rsp_len_q <= wr_idx_q;
						idx_q     <= '0;
						state_q   <= ST_SEND;
					end else if (map_q[page_q]) begin
						state_q <= ST_TAG;
					end else begin
						page_q  <= page_q + 4'h1;
						steps_q <= steps_q + 5'h01;
					end
				end
				ST_TAG: begin
					if (is_stop) begin
						rsp_len_q <= 8'h01;
						cont_q    <= 1'b0;
						idx_q     <= '0;
						state_q   <= ST_SEND;
					end else if (tag_rd_valid) begin
						wr_idx_q <= wr_idx_q + 8'h01;
					end else if (tag_done) begin
						if (tag_xlate(tag_status, tag_iso_code) == EC_NORMAL) begin
							page_q  <= page_q + 4'h1;
							steps_q <= steps_q + 5'h01;
							state_q <= ST_SCAN;
						end else begin
							rsp_len_q <= 8'h01;
							idx_q     <= '0;
							state_q   <= ST_SEND;
						end
					end
				end
				ST_SEND: begin
					if (push && idx_q == rsp_len_q - 8'h01) begin
						state_q <= cont_q ? ST_ACK_WAIT : ST_IDLE;
					end else if (push) begin
						idx_q <= idx_q + 8'h01;
					end
				end
				ST_ACK_WAIT: begin
					if (is_ack) begin
						page_q   <= tag_first_gen ? FIRST_PAGE_GEN1 : 4'h0;
						steps_q  <= '0;
						wr_idx_q <= 8'h01;
						state_q  <= ST_SCAN;
					end else if (is_nack) begin
						idx_q   <= '0;
						state_q <= ST_SEND;
					end else if (is_stop) begin
						rsp_len_q <= 8'h01;
						cont_q    <= 1'b0;
						idx_q     <= '0;
						state_q   <= ST_SEND;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// tag engine strobes and antenna
	// ************************************************************
	// antenna runs from read start until stop or the end of a one-shot read
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tag_req_q   <= 1'b0;
			tag_abort_q <= 1'b0;
			antenna_q   <= 1'b0;
		end else begin
			tag_req_q   <= (state_q == ST_SCAN) && !is_stop && steps_q != 5'(NUM_PAGES) && map_q[page_q];
			tag_abort_q <= (state_q != ST_IDLE) && (state_q != ST_SEND) && is_stop;
			if (state_q != ST_IDLE && state_q != ST_SEND && is_stop) begin
				antenna_q <= 1'b0;
			end else if (state_q == ST_SCAN) begin
				antenna_q <= 1'b1;
			end else if (state_q == ST_SEND && !cont_q) begin
				antenna_q <= 1'b0;
			end
		end
	end

	assign tag_req    = tag_req_q;
	assign tag_page   = page_q;
	assign tag_abort  = tag_abort_q;
	assign antenna_on = antenna_q;

	// ************************************************************
	// response path
	// ************************************************************
	assign push = (state_q == ST_SEND) && f_in_ready;

	rsp_fifo #(
		.WIDTH (9),
		.DEPTH (FIFO_DEPTH)
	) u_rsp_fifo (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.in_valid  (state_q == ST_SEND),
		.in_ready  (f_in_ready),
		.in_data   ({idx_q == rsp_len_q - 8'h01, rsp_mem[idx_q]}),
		.out_valid (f_out_valid),
		.out_ready (tx_ready),
		.out_data  (f_out_data)
	);

	assign tx_valid = f_out_valid;
	assign tx_data  = f_out_data[7:0];
	assign tx_last  = f_out_data[8];

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_parity_code: assert property (rx_valid && rx_last && rx_parity_err |=> fr_err_q == EC_PARITY)
		else $error("parity error not answered with 10");
	a_framing_code: assert property (rx_valid && rx_last && rx_framing_err && !rx_parity_err && !perr_q
		|=> fr_err_q == EC_FRAMING) else $error("framing error not answered with 11");
	a_overrun_code: assert property (rx_valid && rx_last && rx_overrun_err && !rx_parity_err && !perr_q
		&& !rx_framing_err && !ferr_q |=> fr_err_q == EC_OVERRUN) else $error("overrun not answered with 12");
	a_bcc_code: assert property (rx_valid && rx_last && !(perr_q | ferr_q | oerr_q)
		&& !(rx_parity_err | rx_framing_err | rx_overrun_err) && rx_data != bcc_q
		|=> fr_err_q == EC_BCC) else $error("check byte mismatch not answered with 13");
	a_long_frame: assert property (rx_valid && rx_last && !(perr_q | ferr_q | oerr_q)
		&& !(rx_parity_err | rx_framing_err | rx_overrun_err) && rx_data == bcc_q
		&& rx_cnt_q >= 8'(MAX_FRAME) |=> fr_err_q == EC_FRAME) else $error("long frame not answered with 18");
	a_ack_silent: assert property (state_q == ST_IDLE && is_ack |=> state_q == ST_IDLE)
		else $error("acknowledge produced a response");
	a_nack_repeat: assert property (state_q == ST_IDLE && is_nack
		|=> state_q == ST_SEND && idx_q == 8'h00 && rsp_len_q == $past(rsp_len_q))
		else $error("resend did not repeat last response");
	a_echo_length: assert property (state_q == ST_IDLE && cmd_ok && code_q == CMD_ECHO
		|=> rsp_len_q == $past(fr_len_q)
		&& rsp_mem[0] == EC_NORMAL) else $error("echo response length or code wrong");
	a_stop_antenna: assert property ((state_q == ST_TAG || state_q == ST_SCAN) && is_stop
		|=> !antenna_on && tag_abort ##1 !antenna_on) else $error("stop left antenna running");
	a_absent_xlate: assert property (state_q == ST_TAG && !is_stop && !tag_rd_valid && tag_done
		&& tag_status == TST_ISO && tag_iso_code == ISO_ABSENT |=> rsp_mem[0] == EC_ADDR && state_q == ST_SEND)
		else $error("absent block not reported as 7a");

	c_echo_sent: cover property (state_q == ST_SEND && code_q == CMD_ECHO ##1 state_q == ST_IDLE);
	c_read_done: cover property (state_q == ST_SCAN && steps_q == 5'(NUM_PAGES) && wr_idx_q > 8'h01);
	c_cont_reread: cover property (state_q == ST_ACK_WAIT && is_ack);
	c_fifo_full: cover property (state_q == ST_SEND && !f_in_ready);

endmodule : tag_cmd_handler

// ### verilog/tag_cmd_pkg.sv
// constants shared by the tag reader command handler and its testbench
package tag_cmd_pkg;

	// ************************************************************
	// frame limits and buffer sizes
	// ************************************************************
	localparam int         MAX_FRAME   = 73;     // longest legal frame, code through check byte
	localparam int         RSP_DEPTH   = 129;    // end code plus sixteen pages of eight characters
	localparam int         PAGE_CHARS  = 8;      // data characters returned per page
	localparam int         NUM_PAGES   = 16;
	localparam int         READ_LEN    = 5;      // code, option, bank, map high, map low
	localparam logic [3:0] FIRST_PAGE_GEN1 = 4'hb; // first-generation tags start here

	// ************************************************************
	// command codes and modes
	// ************************************************************
	localparam logic [7:0] CMD_ECHO = 8'h10;
	localparam logic [7:0] CMD_ACK  = 8'h11;
	localparam logic [7:0] CMD_NACK = 8'h12;
	localparam logic [7:0] CMD_STOP = 8'h13;
	localparam logic [7:0] CMD_READ = 8'h31;
	localparam logic [7:0] MODE_CONT = 8'h0a;    // continuous multi-tag mode

	// ************************************************************
	// end codes
	// ************************************************************
	localparam logic [7:0] EC_NORMAL  = 8'h00;
	localparam logic [7:0] EC_PARITY  = 8'h10;
	localparam logic [7:0] EC_FRAMING = 8'h11;
	localparam logic [7:0] EC_OVERRUN = 8'h12;
	localparam logic [7:0] EC_BCC     = 8'h13;
	localparam logic [7:0] EC_FORMAT  = 8'h14;
	localparam logic [7:0] EC_FRAME   = 8'h18;
	localparam logic [7:0] EC_COMM    = 8'h70;
	localparam logic [7:0] EC_WRITE   = 8'h71;
	localparam logic [7:0] EC_NOTAG   = 8'h72;
	localparam logic [7:0] EC_CMD     = 8'h79;
	localparam logic [7:0] EC_ADDR    = 8'h7a;

	// ************************************************************
	// tag engine status codes and tag error codes
	// ************************************************************
	localparam logic [2:0] TST_OK    = 3'h0;
	localparam logic [2:0] TST_COMM  = 3'h1;
	localparam logic [2:0] TST_NOTAG = 3'h2;
	localparam logic [2:0] TST_WRITE = 3'h3;
	localparam logic [2:0] TST_ISO   = 3'h4;
	localparam logic [7:0] ISO_ABSENT = 8'h10;
	localparam logic [7:0] ISO_LOCKED = 8'h11;
	localparam logic [7:0] ISO_WPROT  = 8'h12;
	localparam logic [7:0] ISO_WFAIL  = 8'h13;
	localparam logic [7:0] ISO_LFAIL  = 8'h14;

endpackage : tag_cmd_pkg
